// ---- fesf_pkg.sv ----
// constants, types and helpers shared by the error and status flag block
//
// Notes on behaviour
// RQ1 - program that cannot turn targeted bits from one to zero sets program fail
// RQ2 - program into a protected region sets program fail; region stays untouched
// RQ3 - protect config bit 2 or 1 low: nv write changing config one [6:2] fails
// RQ4 - password mode selected: password register update sets program fail
// RQ5 - sector or device erase leaving any bit not one sets erase fail
// RQ6 - erase of a protected region sets erase fail; region stays untouched
// RQ7 - register erase phase of nv register write not all ones: erase fail
// RQ8 - status two bits 7 to 5 reserved zero; host writes zero, reads zero
// RQ9 - status two bit 4 reads one while crc scan is suspended
// RQ10 - crc request with end below start plus 3 sets abort flag, standby
// RQ11 - abort flag clears when next crc scan starts with valid range
// RQ12 - any fail flag keeps busy set and refuses operations until clear command
// RQ13 - host trusts status two only while busy reads zero
// RQ14 - boot self-check failure sets both flags; config load failure sets program
package fesf_pkg;

    // register byte offsets
    localparam logic [7:0] FESF_OFS_STATUS_TWO = 8'h00;
    localparam logic [7:0] FESF_OFS_FAIL = 8'h04;
    localparam logic [7:0] FESF_OFS_CTRL = 8'h08;
    localparam logic [7:0] FESF_OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] FESF_OFS_IRQ_MASK = 8'h10;

    // status two field positions
    localparam int FESF_S2_SUSP_BIT = 4;
    localparam int FESF_S2_ABORT_BIT = 3;
    localparam logic [2:0] FESF_S2_RSVD_VAL = 3'h0;

    // fail register, control register and irq bit positions
    localparam int FESF_PROG_BIT = 0;
    localparam int FESF_ERASE_BIT = 1;
    localparam int FESF_BUSY_BIT = 2;
    localparam int FESF_CRC_ABORT_BIT = 2;
    localparam int FESF_CTRL_CLEAR_BIT = 0;

    // reset values
    localparam logic [2:0] FESF_IRQ_RST = 3'h0;
    localparam logic [2:0] FESF_MASK_RST = 3'h0;
    localparam logic [31:0] FESF_PRDATA_RST = 32'h0000_0000;

    // crc range: end must reach start plus this span
    localparam logic [32:0] FESF_CRC_MIN_SPAN = 33'h0_0000_0003;

    typedef enum logic [2:0] {
        FESF_CRC_IDLE = 3'b001,
        FESF_CRC_RUN  = 3'b010,
        FESF_CRC_SUSP = 3'b100
    } fesf_crc_state_type;

    // true when end address reaches start plus the minimum span
    function automatic logic fesf_crc_range_ok(input logic [31:0] start_a,
                                               input logic [31:0] end_a);
        fesf_crc_range_ok = {1'b0, end_a} >= ({1'b0, start_a} + FESF_CRC_MIN_SPAN);
    endfunction

endpackage

// ---- fesf_crc_ctl.sv ----
// crc scan sequencing with suspend and abort flags
`timescale 1ns/1ps
module fesf_crc_ctl
    import fesf_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic crc_req_i,
    input wire logic [31:0] crc_start_address_i,
    input wire logic [31:0] crc_end_address_i,
    input wire logic crc_suspend_i,
    input wire logic crc_resume_i,
    input wire logic crc_done_i,
    output logic crc_running_o,
    output logic crc_scan_suspended_flag_o,
    output logic crc_scan_aborted_flag_o,
    output logic crc_abort_pulse_o
);

    fesf_crc_state_type state_q;
    fesf_crc_state_type state_d;
    logic aborted_q;
    logic abort_pulse_q;
    logic range_ok;

    assign range_ok = fesf_crc_range_ok(crc_start_address_i, crc_end_address_i);

    // next state of the scan
    always_comb begin
        state_d = state_q;
        case (state_q)
            FESF_CRC_IDLE: begin
                if (crc_req_i && range_ok) begin
                    state_d = FESF_CRC_RUN;
                end
            end
            FESF_CRC_RUN: begin
                if (crc_done_i) begin
                    state_d = FESF_CRC_IDLE;
                end else if (crc_suspend_i) begin
                    state_d = FESF_CRC_SUSP;
                end
            end
            FESF_CRC_SUSP: begin
                if (crc_resume_i) begin
                    state_d = FESF_CRC_RUN;
                end
            end
            default: state_d = FESF_CRC_IDLE;
        endcase
    end

    // state register; bad range leaves scan idle (standby)
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state_q <= FESF_CRC_IDLE;
        end else begin
            state_q <= state_d; // see RQ10
        end
    end

    // abort flag set on bad range, cleared by next good start
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            aborted_q <= 1'b0;
            abort_pulse_q <= 1'b0;
        end else begin
            abort_pulse_q <= 1'b0;
            if (crc_req_i && (state_q == FESF_CRC_IDLE)) begin
                aborted_q <= !range_ok; // see RQ10 see RQ11
                abort_pulse_q <= !range_ok;
            end
        end
    end

    assign crc_running_o = (state_q != FESF_CRC_IDLE);
    assign crc_scan_suspended_flag_o = (state_q == FESF_CRC_SUSP); // see RQ9
    assign crc_scan_aborted_flag_o = aborted_q;
    assign crc_abort_pulse_o = abort_pulse_q;

endmodule // fesf_crc_ctl

// ---- fesf_flags.sv ----
// program and erase failure flags, status two and apb register bank
`timescale 1ns/1ps
module fesf_flags
    import fesf_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // program operation result
    input wire logic prog_done_i,
    input wire logic prog_bits_ok_i,
    input wire logic prog_protected_i,
    // nonvolatile register write to config one
    input wire logic nv_cfg_wr_i,
    input wire logic [7:0] nv_config_one_i,
    input wire logic [7:0] nv_cfg_wdata_i,
    input wire logic [2:0] sector_protect_config_i,
    input wire logic reg_erase_done_i,
    input wire logic reg_erase_ok_i,
    // password register update
    input wire logic pwd_mode_i,
    input wire logic pwd_update_i,
    // erase operation result
    input wire logic erase_done_i,
    input wire logic erase_bits_ok_i,
    input wire logic erase_protected_i,
    // boot checks
    input wire logic boot_check_fail_i,
    input wire logic cfg_load_fail_i,
    // crc scan
    input wire logic crc_req_i,
    input wire logic [31:0] crc_start_address_i,
    input wire logic [31:0] crc_end_address_i,
    input wire logic crc_suspend_i,
    input wire logic crc_resume_i,
    input wire logic crc_done_i,
    // operation control
    input wire logic core_busy_i,
    input wire logic clear_fail_flags_cmd_i,
    output logic program_fail_flag_o,
    output logic erase_fail_flag_o,
    output logic busy_flag_o,
    output logic op_accept_o,
    output logic array_write_veto_o,
    output logic nv_write_veto_o,
    output logic [7:0] status_two_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic prog_fail_q;
    logic erase_fail_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic prog_set;
    logic erase_set;
    logic cfg_locked;
    logic cfg_change;
    logic cfg_lock_err;
    logic pwd_err;
    logic clear_cmd;
    logic apb_setup;
    logic apb_wr;
    logic addr_hit;
    logic crc_susp;
    logic crc_abort;
    logic crc_abort_pulse;
    logic crc_running;
    logic [2:0] irq_set;

    ////////////////////////////////////////////////////////////////////
    // failure conditions

    // config one lock: either protect config bit low
    assign cfg_locked = !sector_protect_config_i[2] || !sector_protect_config_i[1];
    assign cfg_change = (nv_cfg_wdata_i[6:2] != nv_config_one_i[6:2]);
    assign cfg_lock_err = nv_cfg_wr_i && cfg_locked && cfg_change; // see RQ3
    assign pwd_err = pwd_update_i && pwd_mode_i; // see RQ4

    // program fail sources
    assign prog_set = (prog_done_i && !prog_bits_ok_i) // see RQ1
        || (prog_done_i && prog_protected_i) // see RQ2
        || cfg_lock_err
        || pwd_err
        || boot_check_fail_i // see RQ14
        || cfg_load_fail_i; // see RQ14

    // erase fail sources
    assign erase_set = (erase_done_i && !erase_bits_ok_i) // see RQ5
        || (erase_done_i && erase_protected_i) // see RQ6
        || (reg_erase_done_i && !reg_erase_ok_i) // see RQ7
        || boot_check_fail_i; // see RQ14

    // protected regions and locked fields are never altered
    assign array_write_veto_o = prog_protected_i || erase_protected_i; // see RQ2 see RQ6
    assign nv_write_veto_o = cfg_lock_err || pwd_err;

    // clear from the serial command or from software
    assign apb_setup = psel_i && !penable_i;
    assign apb_wr = psel_i && penable_i && pwrite_i;
    assign clear_cmd = clear_fail_flags_cmd_i
        || (apb_wr && (paddr_i == FESF_OFS_CTRL) && pwdata_i[FESF_CTRL_CLEAR_BIT]);

    ////////////////////////////////////////////////////////////////////
    // failure flags; a new failure wins over a clear in the same cycle

    // program fail flag
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            prog_fail_q <= 1'b0;
        end else if (prog_set) begin
            prog_fail_q <= 1'b1;
        end else if (clear_cmd) begin
            prog_fail_q <= 1'b0; // see RQ12
        end
    end

    // erase fail flag
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            erase_fail_q <= 1'b0;
        end else if (erase_set) begin
            erase_fail_q <= 1'b1;
        end else if (clear_cmd) begin
            erase_fail_q <= 1'b0; // see RQ12
        end
    end

    // busy held while a failure is pending; new operations refused
    assign busy_flag_o = core_busy_i || prog_fail_q || erase_fail_q || crc_running; // see RQ12
    assign op_accept_o = !busy_flag_o; // see RQ12
    assign program_fail_flag_o = prog_fail_q;
    assign erase_fail_flag_o = erase_fail_q;

    ////////////////////////////////////////////////////////////////////
    // crc scan and status two

    fesf_crc_ctl u_crc (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .crc_req_i(crc_req_i),
        .crc_start_address_i(crc_start_address_i),
        .crc_end_address_i(crc_end_address_i),
        .crc_suspend_i(crc_suspend_i),
        .crc_resume_i(crc_resume_i),
        .crc_done_i(crc_done_i),
        .crc_running_o(crc_running),
        .crc_scan_suspended_flag_o(crc_susp),
        .crc_scan_aborted_flag_o(crc_abort),
        .crc_abort_pulse_o(crc_abort_pulse)
    );

    // reserved bits read zero; low bits belong to other logic
    always_comb begin
        status_two_o = 8'h00;
        status_two_o[7:5] = FESF_S2_RSVD_VAL; // see RQ8
        status_two_o[FESF_S2_SUSP_BIT] = crc_susp; // see RQ9
        status_two_o[FESF_S2_ABORT_BIT] = crc_abort; // see RQ10
    end

    ////////////////////////////////////////////////////////////////////
    // interrupts

    assign irq_set = {crc_abort_pulse, erase_set, prog_set};

    // sticky status, write one to clear, set wins
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            irq_stat_q <= FESF_IRQ_RST;
        end else if (apb_wr && (paddr_i == FESF_OFS_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~pwdata_i[2:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    // mask register
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            irq_mask_q <= FESF_MASK_RST;
        end else if (apb_wr && (paddr_i == FESF_OFS_IRQ_MASK)) begin
            irq_mask_q <= pwdata_i[2:0];
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////
    // apb read path, captured in the setup cycle

    assign addr_hit = (paddr_i == FESF_OFS_STATUS_TWO) || (paddr_i == FESF_OFS_FAIL)
        || (paddr_i == FESF_OFS_CTRL) || (paddr_i == FESF_OFS_IRQ_STAT)
        || (paddr_i == FESF_OFS_IRQ_MASK);

    // read data and error flag
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            prdata_q <= FESF_PRDATA_RST;
            pslverr_q <= 1'b0;
        end else if (apb_setup) begin
            pslverr_q <= !addr_hit;
            prdata_q <= FESF_PRDATA_RST;
            if (!pwrite_i) begin
                case (paddr_i)
                    FESF_OFS_STATUS_TWO: prdata_q[7:0] <= status_two_o;
                    FESF_OFS_FAIL: begin
                        prdata_q[FESF_PROG_BIT] <= prog_fail_q;
                        prdata_q[FESF_ERASE_BIT] <= erase_fail_q;
                        prdata_q[FESF_BUSY_BIT] <= busy_flag_o;
                    end
                    FESF_OFS_IRQ_STAT: prdata_q[2:0] <= irq_stat_q;
                    FESF_OFS_IRQ_MASK: prdata_q[2:0] <= irq_mask_q;
                    default: prdata_q <= FESF_PRDATA_RST;
                endcase
            end
        end
    end

    assign pready_o = 1'b1;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q && psel_i && penable_i;

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_prog_bad;
        prog_done_i && !prog_bits_ok_i;
    endsequence

    sequence s_clear_alone;
        clear_cmd && !prog_set && !erase_set;
    endsequence

    chk_prog_bits_fail: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ1
        s_prog_bad |=> prog_fail_q && busy_flag_o)
        else $error("program bit failure did not set program fail");

    chk_prog_prot_fail: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ2
        prog_done_i && prog_protected_i |-> array_write_veto_o ##1 prog_fail_q)
        else $error("protected program did not fail or was not vetoed");

    chk_cfg_lock_fail: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ3
        nv_cfg_wr_i && !(sector_protect_config_i[2] && sector_protect_config_i[1])
        && (nv_cfg_wdata_i[6:2] != nv_config_one_i[6:2])
        |-> nv_write_veto_o ##1 prog_fail_q)
        else $error("locked config one change did not fail");

    chk_pwd_update_fail: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ4
        pwd_update_i && pwd_mode_i |=> prog_fail_q)
        else $error("password update in password mode did not fail");

    chk_erase_bits_fail: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ5
        erase_done_i && !erase_bits_ok_i |=> erase_fail_q && !op_accept_o)
        else $error("erase bit failure did not set erase fail");

    chk_erase_prot_fail: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ6
        erase_done_i && erase_protected_i |-> array_write_veto_o ##1 erase_fail_q)
        else $error("protected erase did not fail or was not vetoed");

    chk_reg_erase_fail: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ7
        reg_erase_done_i && !reg_erase_ok_i |=> erase_fail_q)
        else $error("register erase failure did not set erase fail");

    chk_resv_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ8
        status_two_o[7:5] == 3'h0 && status_two_o[2:0] == 3'h0)
        else $error("reserved status two bits not zero");

    chk_crc_susp_flag: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ9
        ((crc_running && !crc_done_i && crc_suspend_i) || status_two_o[FESF_S2_SUSP_BIT])
        && !crc_resume_i |=> status_two_o[FESF_S2_SUSP_BIT])
        else $error("crc suspend flag not held");

    chk_crc_abort_set: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ10
        crc_req_i && !crc_running && !fesf_crc_range_ok(crc_start_address_i, crc_end_address_i)
        |=> status_two_o[FESF_S2_ABORT_BIT] && !crc_running ##1 irq_stat_q[FESF_CRC_ABORT_BIT])
        else $error("bad crc range did not abort");

    chk_crc_abort_clr: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ11
        crc_req_i && !crc_running && fesf_crc_range_ok(crc_start_address_i, crc_end_address_i)
        |=> !status_two_o[FESF_S2_ABORT_BIT] && crc_running)
        else $error("good crc start did not clear abort");

    chk_busy_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ12
        (prog_fail_q || erase_fail_q) |-> busy_flag_o && !op_accept_o)
        else $error("busy dropped while a failure is pending");

    chk_clear_flags: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ12
        s_clear_alone |=> !prog_fail_q && !erase_fail_q)
        else $error("clear command did not clear failure flags");

    chk_boot_fail: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ14
        boot_check_fail_i |=> prog_fail_q && erase_fail_q)
        else $error("boot check failure did not set both flags");

    chk_cfg_load_fail: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RQ14
        cfg_load_fail_i |=> prog_fail_q)
        else $error("config load failure did not set program fail");

endmodule // fesf_flags

// ---- fesf_core_model.sv ----
// flash core model that answers program and erase requests
`timescale 1ns/1ps
module fesf_core_model (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic go_i,
    input wire logic [1:0] kind_i,
    input wire logic ok_i,
    input wire logic prot_i,
    input wire logic [3:0] lat_i,
    output logic busy_o,
    output logic [2:0] done_o,
    output logic ok_o,
    output logic [1:0] prot_o
);
    logic [3:0] cnt_q;
    logic [1:0] kind_q;
    logic ok_q;
    logic prot_q;
    logic act;
    ////////////////////////////////////////////////////////////////////////////////
    // run the requested latency, then pulse the done line of that kind
    always_ff @(posedge core_clk_i) begin
        done_o <= 3'h0;
        if (!rstn_i) begin
            busy_o <= 1'b0;
            cnt_q <= 4'h0;
            kind_q <= 2'h0;
            ok_q <= 1'b0;
            prot_q <= 1'b0;
        end else if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            cnt_q <= lat_i;
            kind_q <= kind_i;
            ok_q <= ok_i;
            prot_q <= prot_i;
        end else if (busy_o && cnt_q == 4'h0) begin
            busy_o <= 1'b0;
            done_o <= 3'h1 << kind_q;
        end else if (busy_o) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    // result level valid only with its pulse, inverted otherwise
    assign act = busy_o | (|done_o);
    assign ok_o = (|done_o) ? ok_q : !ok_q;
    assign prot_o = (act && prot_q) ? (2'h1 << kind_q) : 2'h0;
endmodule // fesf_core_model

// ---- fesf_flags_tb.sv ----
// self-checking bench for the error and status flag block
`timescale 1ns/1ps
module fesf_flags_tb
    import fesf_pkg::*;
;
    logic core_clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
    logic nv_cfg_wr_i, pwd_mode_i, pwd_update_i, boot_check_fail_i, cfg_load_fail_i;
    logic crc_req_i, crc_suspend_i, crc_resume_i, crc_done_i, clear_fail_flags_cmd_i;
    logic program_fail_flag_o, erase_fail_flag_o, busy_flag_o, op_accept_o;
    logic array_write_veto_o, nv_write_veto_o, go, pok, pprot, cbusy, pok_o, er;
    logic [7:0] paddr_i, nv_config_one_i, nv_cfg_wdata_i, status_two_o;
    logic [31:0] pwdata_i, prdata_o, crc_start_address_i, crc_end_address_i, rd, rnd, s;
    logic [2:0] sector_protect_config_i, pdone;
    logic [1:0] pkind, pprot_o;
    logic [3:0] plat;
    logic [31:0] seed = 32'h6A54DBE1;
    int m_pf, m_ef, m_ab, m_su, m_run, m_is, m_mk, n_fail, samples_checked, cyc, i;
    ////////////////////////////////////////////////////////////////////////////////
    fesf_flags i_fesf_flags (.core_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .prog_done_i(pdone[0]),
        .prog_bits_ok_i(pok_o), .prog_protected_i(pprot_o[0]), .nv_cfg_wr_i, .nv_config_one_i,
        .nv_cfg_wdata_i, .sector_protect_config_i, .reg_erase_done_i(pdone[2]),
        .reg_erase_ok_i(pok_o), .pwd_mode_i, .pwd_update_i, .erase_done_i(pdone[1]),
        .erase_bits_ok_i(pok_o), .erase_protected_i(pprot_o[1]), .boot_check_fail_i,
        .cfg_load_fail_i, .crc_req_i, .crc_start_address_i, .crc_end_address_i, .crc_suspend_i,
        .crc_resume_i, .crc_done_i, .core_busy_i(cbusy), .clear_fail_flags_cmd_i,
        .program_fail_flag_o, .erase_fail_flag_o, .busy_flag_o, .op_accept_o,
        .array_write_veto_o, .nv_write_veto_o, .status_two_o, .irq_o);
    fesf_core_model i_fesf_core_model (.core_clk_i, .rstn_i, .go_i(go), .kind_i(pkind),
        .ok_i(pok), .prot_i(pprot), .lat_i(plat), .busy_o(cbusy), .done_o(pdone),
        .ok_o(pok_o), .prot_o(pprot_o));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and cycle ceiling
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // compare every flag output with the model
    task automatic cmp_all();
        logic b;
        repeat (2) @(negedge core_clk_i);
        b = cbusy | m_pf[0] | m_ef[0] | m_run[0] | m_su[0];
        chk({program_fail_flag_o, erase_fail_flag_o, busy_flag_o, op_accept_o, irq_o,
            status_two_o}, {m_pf[0], m_ef[0], b, !b, |(m_is[2:0] & m_mk[2:0]), 3'h0,
            m_su[0], m_ab[0], 3'h0});
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        {psel_i, penable_i} <= 2'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(er, e);
    endtask
    // read the fail register, then clear by command pulse or register write
    task automatic clear_flags(input logic use_reg);
        rd_chk(FESF_OFS_FAIL, {29'h0, 1'b1, m_ef[0], m_pf[0]}, 1'b0);
        if (use_reg) apb(1'b1, FESF_OFS_CTRL, 32'h1);
        else begin
            @(posedge core_clk_i);
            clear_fail_flags_cmd_i <= 1'b1;
            @(posedge core_clk_i);
            clear_fail_flags_cmd_i <= 1'b0;
        end
        m_pf = 0;
        m_ef = 0;
        cmp_all();
    endtask
    // direct events: config write, password update, boot check, config load
    task automatic dev(input int k, input logic [2:0] sp, input logic [7:0] cu,
                       input logic [7:0] nw, input logic pm);
        logic bad;
        bad = (k == 0) ? (!(sp[2] & sp[1]) && cu[6:2] != nw[6:2]) : (k == 1) ? pm : 1'b1;
        @(posedge core_clk_i);
        sector_protect_config_i <= sp;
        nv_config_one_i <= cu;
        nv_cfg_wdata_i <= nw;
        pwd_mode_i <= pm;
        {nv_cfg_wr_i, pwd_update_i, boot_check_fail_i, cfg_load_fail_i} <= 4'h8 >> k;
        @(negedge core_clk_i);
        if (k < 2) chk(nv_write_veto_o, bad);
        @(posedge core_clk_i);
        {nv_cfg_wr_i, pwd_update_i, boot_check_fail_i, cfg_load_fail_i} <= 4'h0;
        nv_cfg_wdata_i <= ~nw;
        m_pf |= bad;
        m_ef |= (k == 2);
        m_is |= {k == 2, bad};
        cmp_all();
        if (m_pf != 0) clear_flags(xs() & 1);
    endtask
    // core operation through the partner: 0 program, 1 erase, 2 register erase
    task automatic cop(input int k, input logic ok, input logic pr);
        rnd = xs();
        @(posedge core_clk_i);
        go <= 1'b1;
        pkind <= k[1:0];
        pok <= ok;
        pprot <= pr;
        plat <= {1'b0, rnd[2:0]};
        @(posedge core_clk_i);
        go <= 1'b0;
        @(negedge core_clk_i);
        chk(array_write_veto_o, pr && k < 2);
        while (pdone === 3'h0) @(negedge core_clk_i);
        m_pf |= (!ok || pr) && k == 0;
        m_ef |= (!ok || (pr && k < 2)) && k != 0;
        m_is |= m_pf | (m_ef << 1);
        cmp_all();
        if (m_pf != 0 || m_ef != 0) clear_flags(rnd[4]);
    endtask
    task automatic crc(input logic [31:0] st, input logic [31:0] en);
        @(posedge core_clk_i);
        crc_req_i <= 1'b1;
        crc_start_address_i <= st;
        crc_end_address_i <= en;
        @(posedge core_clk_i);
        crc_req_i <= 1'b0;
        {crc_start_address_i, crc_end_address_i} <= ~{st, en};
        if (m_run == 0 && m_su == 0) begin
            m_ab = ({1'b0, en} < {1'b0, st} + 33'h3);
            m_run = !m_ab;
            m_is |= m_ab << 2;
        end
        cmp_all();
    endtask
    // crc control pulse: 0 suspend, 1 resume, 2 done
    task automatic cp(input int k);
        @(posedge core_clk_i);
        {crc_suspend_i, crc_resume_i, crc_done_i} <= 3'h4 >> k;
        @(posedge core_clk_i);
        {crc_suspend_i, crc_resume_i, crc_done_i} <= 3'h0;
        if (k == 0 && m_run != 0) {m_su, m_run} = {32'd1, 32'd0};
        else if (k == 1 && m_su != 0) {m_su, m_run} = {32'd0, 32'd1};
        else if (k == 2) m_run = 0;
        cmp_all();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rstn_i, psel_i, penable_i, pwrite_i, nv_cfg_wr_i, pwd_mode_i, pwd_update_i} = 0;
        {boot_check_fail_i, cfg_load_fail_i, crc_req_i, crc_suspend_i, crc_resume_i} = 0;
        {crc_done_i, clear_fail_flags_cmd_i, go, pok, pprot, pkind, plat} = 0;
        {paddr_i, pwdata_i, nv_config_one_i, nv_cfg_wdata_i, sector_protect_config_i} = 0;
        {crc_start_address_i, crc_end_address_i} = 0;
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        for (i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0, i == 5);
        apb(1'b1, 8'h14, 32'hFFFFFFFF);
        apb(1'b1, FESF_OFS_FAIL, 32'h7);
        apb(1'b1, FESF_OFS_IRQ_MASK, 32'h7);
        m_mk = 7;
        rd_chk(FESF_OFS_IRQ_MASK, 32'h7, 1'b0);
        rd_chk(FESF_OFS_FAIL, 32'h0, 1'b0);
        $display("test register map done");
        for (i = 0; i < 24; i++) begin
            rnd = xs();
            s = (i % 3 == 0) ? rnd : (i % 3 == 1) ? rnd ^ 32'h83 : rnd ^ (32'h4 << (i % 5));
            dev(0, i[2:0], rnd[7:0], s[7:0], 1'b0);
            dev(1, i[2:0], rnd[7:0], s[7:0], i[3]);
        end
        dev(2, 3'h7, 8'h0, 8'h0, 1'b0);
        dev(3, 3'h7, 8'h0, 8'h0, 1'b0);
        $display("test direct events done");
        for (i = 0; i < 30; i++) begin
            rnd = xs();
            cop(i % 3, rnd[0] | rnd[1], rnd[2] & rnd[3]);
        end
        rd_chk(FESF_OFS_IRQ_STAT, {29'h0, m_is[2:0]}, 1'b0);
        apb(1'b1, FESF_OFS_IRQ_STAT, 32'h7);
        m_is = 0;
        apb(1'b1, FESF_OFS_IRQ_MASK, 32'h5);
        m_mk = 5;
        cop(1, 1'b0, 1'b0);
        $display("test core ops done");
        for (i = 0; i < 4; i++) begin
            s = xs();
            crc(s, s + 32'h2);
            crc(s, s + 32'h3);
            crc(s, s);
            cp(0);
            crc(s, s + 32'h1);
            cp(1);
            cp(2);
            rd_chk(FESF_OFS_STATUS_TWO, {28'h0, m_ab[0], 3'h0}, 1'b0);
            crc(s, s - 32'h1);
        end
        rd_chk(FESF_OFS_IRQ_STAT, {29'h0, m_is[2:0]}, 1'b0);
        apb(1'b1, FESF_OFS_IRQ_STAT, 32'h4);
        m_is &= 3;
        cmp_all();
        $display("test crc scan done");
        summarize();
    end
endmodule // fesf_flags_tb
